/* verilog/dac_cmd_decoder.sv */
// Command word decoder of the 40-channel converter
`timescale 1ns/1ps

module dac_cmd_decoder
   import dac_cmd_pkg::*;
(
   input  wire logic                         CORE_CLK,
   input  wire logic                         NRST,
   input  wire logic                         CLK_EN,
   input  wire logic                         LINK_SCLK,
   input  wire logic                         FRAME_SYNC_N,
   input  wire logic                         SERIAL_DIN,
   input  wire logic                         OVERTEMP_PIN,
   output logic                              CHAN_WRITE,
   output logic [dac_cmd_pkg::CHAN_TOTAL-1:0] CHAN_MASK,
   output dac_cmd_pkg::target_t              CHAN_TARGET,
   output logic [dac_cmd_pkg::DATA_W-1:0]    CHAN_DATA,
   output logic                              INPUT_SIDE_B,
   output logic                              THERMAL_SD_EN,
   output logic                              POWER_DOWN,
   output logic [dac_cmd_pkg::CTRL_W-1:0]    CONTROL_READ,
   output logic [dac_cmd_pkg::DATA_W-1:0]    OFFSET_CODE_0,
   output logic [dac_cmd_pkg::DATA_W-1:0]    OFFSET_CODE_1,
   output logic [dac_cmd_pkg::DATA_W-1:0]    OFFSET_CODE_2,
   output logic [dac_cmd_pkg::SEL_W-1:0]     SIDE_SELECT_0,
   output logic [dac_cmd_pkg::SEL_W-1:0]     SIDE_SELECT_1,
   output logic [dac_cmd_pkg::SEL_W-1:0]     SIDE_SELECT_2,
   output logic [dac_cmd_pkg::SEL_W-1:0]     SIDE_SELECT_3,
   output logic [dac_cmd_pkg::SEL_W-1:0]     SIDE_SELECT_4,
   output logic                              READBACK_PENDING,
   output logic [dac_cmd_pkg::RB_W-1:0]      READBACK_SELECT,
   output logic [dac_cmd_pkg::DATA_W-1:0]    READBACK_DATA,
   output logic                              WORD_REJECTED
);
   import dac_cmd_pkg::*;

   // ==========================================================
   // Layout check: the mask loop assumes eight channels a group
   initial begin
      if (CHAN_TOTAL != GROUPS * CHANS || CHANS != 8) begin
         $error("dac_cmd_decoder: channel layout does not fit");
      end
   end

   // ==========================================================
   // Link side and crossing
   logic [WORD_W-1:0] shift_word;
   logic [CNT_W-1:0]  bit_count;
   logic [1:0]        synced;
   logic              frame_active;
   logic              frame_active_d;
   logic              overtemp;

   link_shift_in u_link (
      .link_clk   (LINK_SCLK),
      .frame_n    (FRAME_SYNC_N),
      .data_in    (SERIAL_DIN),
      .shift_word (shift_word),
      .bit_count  (bit_count)
   );

   level_sync #(
      .WIDTH  (2),
      .STAGES (2)
   ) u_sync (
      .clk      (CORE_CLK),
      .rst_n    (NRST),
      .en       (CLK_EN),
      .async_in ({OVERTEMP_PIN, !FRAME_SYNC_N}),
      .sync_out (synced)
   );

   // Active level is synced, so cleared stages match an idle pin
   // and no false frame end follows a reset
   assign frame_active = synced[0];
   assign overtemp   = synced[1];

   // ==========================================================
   // Frame-end sequencing
   // Word and count are quiet while the frame is high, so they
   // are sampled only once the synchronised rise has been seen
   state_t            state;
   state_t            next_state;
   logic [WORD_W-1:0] word;
   logic              word_ok;
   wire               frame_rise = !frame_active && frame_active_d;

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE:   if (frame_rise) next_state = ST_SETTLE;
         ST_SETTLE: next_state = ST_DECODE;
         ST_DECODE: next_state = ST_IDLE;
         default:   next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         state          <= ST_IDLE;
         frame_active_d <= 1'b0;
         word         <= '0;
         word_ok      <= 1'b0;
      end else if (CLK_EN) begin
         state          <= next_state;
         frame_active_d <= frame_active;
         if (state == ST_SETTLE) begin
            word    <= shift_word;
            word_ok <= (bit_count == WORD_BITS);
         end
      end
   end

   // ==========================================================
   // Field decode
   wire               execute  = (state == ST_DECODE) && word_ok;
   wire [1:0]         mode     = word[MODE_MSB:MODE_LSB];
   wire [2:0]         addr_up  = word[ADDR_MSB:ADDR_MID];
   wire [2:0]         addr_low = word[ADDR_SPLIT:ADDR_LSB];
   wire [DATA_W-1:0]  data     = word[DATA_MSB:DATA_LSB];
   wire [5:0]         func     = word[FUNC_MSB:FUNC_LSB];
   wire [ARG_MSB:0]   arg      = word[ARG_MSB:0];
   wire               special  = (mode == MODE_SPECIAL);
   wire               addr_rsv = (addr_up == UP_BROADCAST)
                                 && (addr_low >= LOW_RSV_FROM);
   wire               broad    = (addr_up == UP_BROADCAST);

   // ==========================================================
   // Channel selection, one group of eight per loop pass
   logic [CHAN_TOTAL-1:0] mask;

   for (genvar g = 0; g < GROUPS; g++) begin : g_group
      wire grp_hit =
         (addr_up == 3'(g + 1))
         || (broad && (addr_low == LOW_ALL
                       || addr_low == 3'(g + 1)))
         || (addr_up == UP_ALL_GRP)
         || (addr_up == UP_GRP_1TO4 && g != 0);
      for (genvar c = 0; c < CHANS; c++) begin : g_chan
         assign mask[g*CHANS + c] =
            grp_hit && (broad || addr_low == 3'(c));
      end
   end

   // ==========================================================
   // Channel write path
   logic [2:0] ctrl;
   target_t    target;

   always_comb begin
      case (mode)
         MODE_INPUT:  target = ctrl[CTRL_SIDE_BIT] ? TGT_INPUT_B
                                                    : TGT_INPUT_A;
         MODE_OFFSET: target = TGT_OFFSET;
         MODE_GAIN:   target = TGT_GAIN;
         default:     target = TGT_INPUT_A;
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         CHAN_WRITE  <= 1'b0;
         CHAN_MASK   <= '0;
         CHAN_TARGET <= TGT_INPUT_A;
         CHAN_DATA   <= '0;
      end else if (CLK_EN) begin
         CHAN_WRITE <= execute && !special && !addr_rsv;
         if (execute && !special && !addr_rsv) begin
            CHAN_MASK   <= mask;
            CHAN_TARGET <= target;
            CHAN_DATA   <= data;
         end
      end
   end

   // ==========================================================
   // Special function registers
   logic [DATA_W-1:0] ofs [3];
   logic [SEL_W-1:0]  sel [GROUPS];
   logic [RB_W-1:0]   rb_sel;
   logic              rb_pend;
   wire               fn_go   = execute && special;
   wire [5:0]         ofs_idx = func - FN_OFFSET_DAC_CODE_0;
   wire [5:0]         sel_idx = func - FN_SEL0;

   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         ctrl <= CTRL_RESET;
         for (int i = 0; i < 3; i++) begin
            ofs[i] <= OFS_RESET;
         end
         for (int i = 0; i < GROUPS; i++) begin
            sel[i] <= SEL_RESET;
         end
      end else if (CLK_EN && fn_go) begin
         // Bits 4 and 3 of the argument are not stored
         if (func == FN_CTRL) begin
            ctrl <= arg[CTRL_SIDE_BIT:CTRL_PD_BIT];
         end
         if (func >= FN_OFFSET_DAC_CODE_0 && func <= FN_OFFSET_DAC_CODE_2) begin
            ofs[ofs_idx[1:0]] <= arg[ARG_OFS_MSB:0];
         end
         if (func >= FN_SEL0 && func <= FN_SEL4) begin
            sel[sel_idx[2:0]] <= arg[ARG_SEL_MSB:0];
         end
         if (func == FN_SEL_BLOCK) begin
            for (int i = 0; i < GROUPS; i++) begin
               // Any nonzero low byte of the argument is taken as all ones
               sel[i] <= (arg[ARG_SEL_MSB:0] == SEL_RESET)
                         ? SEL_RESET : SEL_ALL_B;
            end
         end
      end
   end

   // ==========================================================
   // Readback selection
   // Pending lasts one further frame; a new select in that frame
   // wins over the clear
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         rb_sel  <= RB_NONE;
         rb_pend <= 1'b0;
      end else if (CLK_EN && state == ST_DECODE) begin
         if (fn_go && func == FN_RB_SEL) begin
            rb_sel  <= arg[ARG_MSB:RB_LSB];
            rb_pend <= 1'b1;
         end else begin
            rb_pend <= 1'b0;
         end
      end
   end

   wire [CTRL_W-1:0] ctrl_view = {overtemp, 1'b0, ctrl};
   logic [DATA_W-1:0] rb_data;

   always_comb begin
      case (rb_sel)
         RB_CTRL: rb_data = {9'h000, ctrl_view};
         RB_OFFSET_DAC_CODE_0: rb_data = ofs[0];
         RB_OFFSET_DAC_CODE_1: rb_data = ofs[1];
         RB_OFFSET_DAC_CODE_2: rb_data = ofs[2];
         RB_SEL0: rb_data = {6'h00, sel[0]};
         RB_SEL1: rb_data = {6'h00, sel[1]};
         RB_SEL2: rb_data = {6'h00, sel[2]};
         RB_SEL3: rb_data = {6'h00, sel[3]};
         RB_SEL4: rb_data = {6'h00, sel[4]};
         default: rb_data = '0;
      endcase
   end

   // ==========================================================
   // Output registers
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         READBACK_DATA <= '0;
         WORD_REJECTED <= 1'b0;
         CONTROL_READ  <= '0;
      end else if (CLK_EN) begin
         READBACK_DATA <= rb_data;
         WORD_REJECTED <= (state == ST_DECODE) && !word_ok;
         CONTROL_READ  <= ctrl_view;
      end
   end

   assign INPUT_SIDE_B     = ctrl[CTRL_SIDE_BIT];
   assign THERMAL_SD_EN    = ctrl[CTRL_TSD_BIT];
   assign POWER_DOWN       = ctrl[CTRL_PD_BIT];
   assign OFFSET_CODE_0    = ofs[0];
   assign OFFSET_CODE_1    = ofs[1];
   assign OFFSET_CODE_2    = ofs[2];
   assign SIDE_SELECT_0    = sel[0];
   assign SIDE_SELECT_1    = sel[1];
   assign SIDE_SELECT_2    = sel[2];
   assign SIDE_SELECT_3    = sel[3];
   assign SIDE_SELECT_4    = sel[4];
   assign READBACK_PENDING = rb_pend;
   assign READBACK_SELECT  = rb_sel;
endmodule // dac_cmd_decoder

/* verilog/dac_cmd_pkg.sv */
// Shared constants and types of the converter command decoder
package dac_cmd_pkg;

   // ==========================================================
   // Serial word layout
   localparam int WORD_W     = 24;
   localparam int DATA_W     = 14;
   localparam int MODE_MSB   = 23;
   localparam int MODE_LSB   = 22;
   localparam int ADDR_MSB   = 21;
   localparam int ADDR_MID   = 19;
   localparam int ADDR_SPLIT = 18;
   localparam int ADDR_LSB   = 16;
   localparam int DATA_MSB   = 15;
   localparam int DATA_LSB   = 2;
   localparam int FUNC_MSB   = 21;
   localparam int FUNC_LSB   = 16;
   localparam int ARG_MSB    = 15;
   localparam int ARG_OFS_MSB = 13;
   localparam int ARG_SEL_MSB = 7;
   localparam int RB_LSB     = 7;
   localparam int RB_W       = 9;

   // ==========================================================
   // Bit counter of the link receiver
   localparam int           CNT_W     = 5;
   localparam logic [4:0]   CNT_MAX   = 5'h1F;
   localparam logic [4:0]   WORD_BITS = 5'h18;

   // ==========================================================
   // Mode field and addressing
   localparam logic [1:0] MODE_SPECIAL = 2'h0;
   localparam logic [1:0] MODE_GAIN    = 2'h1;
   localparam logic [1:0] MODE_OFFSET  = 2'h2;
   localparam logic [1:0] MODE_INPUT   = 2'h3;

   localparam int         GROUPS       = 5;
   localparam int         CHANS        = 8;
   localparam int         CHAN_TOTAL   = 40;
   localparam logic [2:0] UP_BROADCAST = 3'h0;
   localparam logic [2:0] UP_ALL_GRP   = 3'h6;
   localparam logic [2:0] UP_GRP_1TO4  = 3'h7;
   localparam logic [2:0] LOW_ALL      = 3'h0;
   localparam logic [2:0] LOW_RSV_FROM = 3'h6;

   // ==========================================================
   // Special function codes
   localparam logic [5:0] FN_NOP       = 6'h00;
   localparam logic [5:0] FN_CTRL      = 6'h01;
   localparam logic [5:0] FN_OFFSET_DAC_CODE_0      = 6'h02;
   localparam logic [5:0] FN_OFFSET_DAC_CODE_2      = 6'h04;
   localparam logic [5:0] FN_RB_SEL    = 6'h05;
   localparam logic [5:0] FN_SEL0      = 6'h06;
   localparam logic [5:0] FN_SEL4      = 6'h0A;
   localparam logic [5:0] FN_SEL_BLOCK = 6'h0B;

   // ==========================================================
   // Control register
   localparam int         CTRL_W        = 5;
   localparam int         CTRL_PD_BIT   = 0;
   localparam int         CTRL_TSD_BIT  = 1;
   localparam int         CTRL_SIDE_BIT = 2;
   localparam int         CTRL_OT_BIT   = 4;
   localparam logic [2:0] CTRL_RESET    = 3'h0;
   localparam logic [13:0] OFS_RESET    = 14'h0000;
   localparam int         SEL_W         = 8;
   localparam logic [7:0] SEL_RESET     = 8'h00;
   localparam logic [7:0] SEL_ALL_B     = 8'hFF;

   // ==========================================================
   // Readback codes for the internal registers
   localparam logic [8:0] RB_CTRL = 9'h101;
   localparam logic [8:0] RB_OFFSET_DAC_CODE_0 = 9'h102;
   localparam logic [8:0] RB_OFFSET_DAC_CODE_1 = 9'h103;
   localparam logic [8:0] RB_OFFSET_DAC_CODE_2 = 9'h104;
   localparam logic [8:0] RB_SEL0 = 9'h106;
   localparam logic [8:0] RB_SEL1 = 9'h107;
   localparam logic [8:0] RB_SEL2 = 9'h108;
   localparam logic [8:0] RB_SEL3 = 9'h109;
   localparam logic [8:0] RB_SEL4 = 9'h10A;
   localparam logic [8:0] RB_NONE = 9'h000;

   typedef enum logic [1:0] {
      TGT_INPUT_A = 2'b00,
      TGT_INPUT_B = 2'b01,
      TGT_OFFSET  = 2'b10,
      TGT_GAIN    = 2'b11
   } target_t;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_SETTLE = 2'b01,
      ST_DECODE = 2'b10
   } state_t;

endpackage

/* verilog/level_sync.sv */
// Multi-stage synchroniser for asynchronous levels
`timescale 1ns/1ps
module level_sync #(
   parameter int WIDTH  = 1,
   parameter int STAGES = 2
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             en,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage [STAGES];

   initial begin
      if (STAGES < 2 || WIDTH < 1) begin
         $error("level_sync: needs two stages and one bit at least");
      end
   end

   // First stage feeds only the next stage
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < STAGES; i++) begin
            stage[i] <= '0;
         end
      end else if (en) begin
         stage[0] <= async_in;
         for (int i = 1; i < STAGES; i++) begin
            stage[i] <= stage[i-1];
         end
      end
   end

   assign sync_out = stage[STAGES-1];
endmodule // level_sync

/* verilog/link_shift_in.sv */
// Serial word receiver on the link clock
`timescale 1ns/1ps
module link_shift_in
   import dac_cmd_pkg::*;
(
   input  wire logic              link_clk,
   input  wire logic              frame_n,
   input  wire logic              data_in,
   output logic      [WORD_W-1:0] shift_word,
   output logic      [CNT_W-1:0]  bit_count
);
   logic [CNT_W-1:0] run_count;

   // ==========================================================
   // Frame high clears the count with no link edge needed,
   // since a gated clock stops once the frame ends
   always_ff @(negedge link_clk or posedge frame_n) begin
      if (frame_n) begin
         run_count <= '0;
      end else if (run_count != CNT_MAX) begin
         run_count <= run_count + 5'h01;
      end
   end

   // Count frozen at the frame end, before the clear lands;
   // it then stays quiet until the core has sampled it
   always_ff @(posedge frame_n) begin
      bit_count <= run_count;
   end

   // Bits arrive most significant first on the falling edge
   always_ff @(negedge link_clk) begin
      if (!frame_n) begin
         shift_word <= {shift_word[WORD_W-2:0], data_in};
      end
   end
endmodule // link_shift_in

/* verif/dac_cmd_monitor.sv */
// Concurrent checks on the command decoder ports
`timescale 1ns/1ps
module dac_cmd_monitor
   import dac_cmd_pkg::*;
(
   input wire logic                              CORE_CLK,
   input wire logic                              NRST,
   input wire logic                              FRAME_SYNC_N,
   input wire logic                              OVERTEMP_PIN,
   input wire logic                              CHAN_WRITE,
   input wire logic [dac_cmd_pkg::CHAN_TOTAL-1:0] CHAN_MASK,
   input wire dac_cmd_pkg::target_t              CHAN_TARGET,
   input wire logic                              INPUT_SIDE_B,
   input wire logic [dac_cmd_pkg::CTRL_W-1:0]    CONTROL_READ,
   input wire logic [dac_cmd_pkg::DATA_W-1:0]    OFFSET_CODE_0,
   input wire logic [dac_cmd_pkg::SEL_W-1:0]     SIDE_SELECT_0,
   input wire logic [dac_cmd_pkg::SEL_W-1:0]     SIDE_SELECT_4,
   input wire logic                              READBACK_PENDING,
   input wire logic [dac_cmd_pkg::RB_W-1:0]      READBACK_SELECT,
   input wire logic                              WORD_REJECTED
);
   // ==========================================================
   // Frame age: deep inside a frame no register may move
   logic [3:0] low_cnt;
   always_ff @(posedge CORE_CLK) begin
      if (!NRST || FRAME_SYNC_N) low_cnt <= 4'h0;
      else if (low_cnt != 4'hF) low_cnt <= low_cnt + 4'h1;
   end
   wire logic [41:0] regs = {OFFSET_CODE_0, SIDE_SELECT_0, SIDE_SELECT_4,
                             READBACK_SELECT, CONTROL_READ[2:0]};

   // ==========================================================
   // Assertions
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);

   write_pulse_a: assert property (CHAN_WRITE |=> !CHAN_WRITE)
      else $error("channel write pulse too long");
   mask_hit_a: assert property (CHAN_WRITE |-> CHAN_MASK != '0)
      else $error("channel write with empty mask");
   mask_hold_a: assert property ($changed(CHAN_MASK) |-> CHAN_WRITE)
      else $error("mask moved without a write");
   side_route_a: assert property (
      CHAN_WRITE && !CHAN_TARGET[1] |-> CHAN_TARGET[0] == INPUT_SIDE_B)
      else $error("input write went to the wrong side");
   overtemp_a: assert property (
      $stable(OVERTEMP_PIN) [*5] |-> CONTROL_READ[4] == OVERTEMP_PIN)
      else $error("overtemperature bit does not follow the pin");
   frame_quiet_a: assert property (low_cnt > 4'h8 |-> $stable(regs))
      else $error("register changed in mid frame");
   reject_pulse_a: assert property (
      WORD_REJECTED |-> !CHAN_WRITE ##1 !WORD_REJECTED)
      else $error("reject pulse malformed");
   block_sel_a: assert property (
      $changed(SIDE_SELECT_0) && $changed(SIDE_SELECT_4) |->
      SIDE_SELECT_0 == SIDE_SELECT_4 && SIDE_SELECT_0 inside {8'h00, 8'hFF})
      else $error("block select not uniform");
   rb_pending_a: assert property (
      $changed(READBACK_SELECT) |-> ##[0:1] READBACK_PENDING)
      else $error("readback select without pending flag");

   cover property (CHAN_WRITE && CHAN_MASK == {CHAN_TOTAL{1'b1}});
   cover property (WORD_REJECTED);
   cover property ($rose(READBACK_PENDING));
endmodule // dac_cmd_monitor

bind dac_cmd_decoder dac_cmd_monitor u_dac_cmd_monitor (
   .CORE_CLK, .NRST, .FRAME_SYNC_N, .OVERTEMP_PIN, .CHAN_WRITE,
   .CHAN_MASK, .CHAN_TARGET, .INPUT_SIDE_B, .CONTROL_READ,
   .OFFSET_CODE_0, .SIDE_SELECT_0, .SIDE_SELECT_4,
   .READBACK_PENDING, .READBACK_SELECT, .WORD_REJECTED
);

/* verif/link_host_model.sv */
// Behavioural host driving command frames onto the serial link
`timescale 1ns/1ps
module link_host_model (
   output logic sclk,
   output logic sync_n,
   output logic din
);
   initial begin
      sclk   = 1'b1;
      sync_n = 1'b1;
      din    = 1'b0;
   end

   // ==========================================================
   // One frame, MSB first; n other than 24 gives a bad frame
   task automatic frame(input logic [24:0] w, input int n);
      #7;
      sync_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         din = w[i];
         #40 sclk = 1'b0;
         #40 sclk = 1'b1;
      end
      #20 sync_n = 1'b1;
      // Released line shows the inverse, never a stale bit
      din = ~din;
   endtask
endmodule // link_host_model

/* verif/multichannel_dac_command_decoder_bench.sv */
// Self-checking bench of the command decoder
`timescale 1ns/1ps
module multichannel_dac_command_decoder_bench;
   import dac_cmd_pkg::*;

   logic        core_clk, nrst, overtemp, sclk, sync_n, din, clk_en;
   logic        chan_write, rejected, side_b, tsd_en, pwr_dn, rb_pend;
   logic [39:0] chan_mask;
   target_t     chan_target;
   logic [13:0] chan_data, rb_data;
   logic [13:0] ofs [3];
   logic [7:0]  sel [5];
   logic [4:0]  ctrl_rd;
   logic [8:0]  rb_sel;
   logic [95:0] s;
   logic [39:0] em;
   int          n_mismatch = 0;
   int          num_checks = 0;
   int          n_wr = 0;
   int          n_rej = 0;
   int          k, r;

   dac_cmd_decoder u_dac_cmd_decoder (
      .CORE_CLK(core_clk), .NRST(nrst), .CLK_EN(clk_en),
      .LINK_SCLK(sclk), .FRAME_SYNC_N(sync_n), .SERIAL_DIN(din),
      .OVERTEMP_PIN(overtemp), .CHAN_WRITE(chan_write),
      .CHAN_MASK(chan_mask), .CHAN_TARGET(chan_target),
      .CHAN_DATA(chan_data), .INPUT_SIDE_B(side_b),
      .THERMAL_SD_EN(tsd_en), .POWER_DOWN(pwr_dn),
      .CONTROL_READ(ctrl_rd), .OFFSET_CODE_0(ofs[0]),
      .OFFSET_CODE_1(ofs[1]), .OFFSET_CODE_2(ofs[2]),
      .SIDE_SELECT_0(sel[0]), .SIDE_SELECT_1(sel[1]),
      .SIDE_SELECT_2(sel[2]), .SIDE_SELECT_3(sel[3]),
      .SIDE_SELECT_4(sel[4]), .READBACK_PENDING(rb_pend),
      .READBACK_SELECT(rb_sel), .READBACK_DATA(rb_data),
      .WORD_REJECTED(rejected));
   link_host_model u_link_host_model (.sclk, .sync_n, .din);

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      if (chan_write === 1'b1) n_wr++;
      if (rejected === 1'b1) n_rej++;
   end

   // ==========================================================
   // Helpers
   task automatic chk(input string nm, input logic [95:0] e, g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Waits out the decode pipeline, well past the idle gap
   task automatic send(input logic [24:0] w, input int n = 24);
      u_link_host_model.frame(w, n);
      repeat (16) @(negedge core_clk);
   endtask

   task automatic sf(input logic [5:0] f, input logic [15:0] a);
      send({3'h0, f, a});
   endtask

   task automatic cw(input logic [1:0] m, input logic [5:0] a,
                     input logic [13:0] d);
      send({1'b0, m, a, d, 2'h0});
   endtask

   function automatic logic [95:0] snap();
      return {ofs[0], ofs[1], ofs[2], sel[0], sel[1], sel[2], sel[3],
              sel[4], ctrl_rd, rb_sel};
   endfunction

   function automatic logic [39:0] exp_mask(input logic [5:0] a);
      logic [39:0] m;
      m = '0;
      for (int g = 0; g < 5; g++) begin
         if (a[5:3] == 3'h0 && (a[2:0] == 3'h0 || a[2:0] == 3'(g + 1)))
            m[g*8 +: 8] = 8'hFF;
         if (a[5:3] == 3'(g + 1) || a[5:3] == 3'h6 ||
             (a[5:3] == 3'h7 && g > 0))
            m[g*8 + int'(a[2:0])] = 1'b1;
      end
      return m;
   endfunction

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Tests
   initial begin
      nrst     = 1'b0;
      overtemp = 1'b0;
      clk_en   = 1'b1;
      repeat (8) @(negedge core_clk);
      nrst = 1'b1;
      repeat (4) @(negedge core_clk);
      chk("reset regs", '0, snap());
      $display("test reset done");

      for (int a = 0; a < 64; a++) begin
         k  = n_wr;
         em = exp_mask(6'(a));
         cw(2'h3, 6'(a), 14'h02A5 ^ 14'(a));
         chk("write count", k + (em != '0), n_wr);
         if (em != '0) begin
            chk("mask", em, chan_mask);
            chk("data", 14'h02A5 ^ 14'(a), chan_data);
            chk("target", TGT_INPUT_A, chan_target);
         end
      end
      cw(2'h1, 6'h08, 14'h3FFF);
      chk("gain", TGT_GAIN, chan_target);
      cw(2'h2, 6'h08, 14'h0001);
      chk("offset", TGT_OFFSET, chan_target);
      $display("test addressing done");

      for (int v = 2; v <= 5; v += 3) begin
         sf(FN_CTRL, 16'(v));
         chk("control", v, {side_b, tsd_en, pwr_dn});
         chk("control read", v, ctrl_rd);
         cw(2'h3, 6'h09, 14'h0155);
         chk("side", v[2] ? TGT_INPUT_B : TGT_INPUT_A, chan_target);
      end
      $display("test control done");

      for (int i = 0; i < 3; i++) begin
         sf(FN_OFFSET_DAC_CODE_0 + 6'(i), {2'h3, 14'h1A5C + 14'(i)});
         chk("offset reg", 14'h1A5C + 14'(i), ofs[i]);
      end
      for (int i = 0; i < 5; i++) begin
         sf(FN_SEL0 + 6'(i), {8'hA5, 8'(17 * i + 3)});
         chk("select reg", 8'(17 * i + 3), sel[i]);
      end
      $display("test registers done");

      sf(FN_RB_SEL, {RB_OFFSET_DAC_CODE_1, 7'h7F});
      chk("rb select", RB_OFFSET_DAC_CODE_1, rb_sel);
      chk("rb data", 14'h1A5D, rb_data);
      chk("rb pending", 1'b1, rb_pend);
      sf(FN_RB_SEL, {RB_SEL2, 7'h00});
      chk("rb data", 14'h0025, rb_data);
      sf(FN_NOP, 16'h0000);
      chk("rb pending", 1'b0, rb_pend);
      $display("test readback done");

      s = snap();
      k = n_wr;
      r = n_rej;
      sf(6'h0C, 16'hFFFF);
      sf(6'h3F, 16'hFFFF);
      cw(2'h3, 6'h06, 14'h1111);
      send({3'h0, FN_OFFSET_DAC_CODE_0, 16'h3FFF}, 23);
      send({3'h0, FN_OFFSET_DAC_CODE_0, 16'h3FFF}, 25);
      chk("quiet regs", s, snap());
      chk("quiet writes", k, n_wr);
      chk("rejects", r + 2, n_rej);
      $display("test refusals done");

      sf(FN_SEL_BLOCK, 16'hFF00);
      s = snap();
      chk("block zero", '0, s[53:14]);
      sf(FN_SEL_BLOCK, 16'h00FF);
      s = snap();
      chk("block ones", {40{1'b1}}, s[53:14]);
      $display("test block done");

      // A frame sent wholly while the core is frozen is never seen
      clk_en = 1'b0;
      sf(FN_OFFSET_DAC_CODE_0, 16'h0123);
      clk_en = 1'b1;
      repeat (4) @(negedge core_clk);
      chk("frozen offset", 14'h1A5C, ofs[0]);
      $display("test clock enable done");

      overtemp = 1'b1;
      repeat (8) @(negedge core_clk);
      chk("overtemp", 1'b1, ctrl_rd[4]);
      overtemp = 1'b0;
      nrst     = 1'b0;
      repeat (8) @(negedge core_clk);
      nrst = 1'b1;
      repeat (4) @(negedge core_clk);
      chk("second reset", '0, snap());
      $display("test overtemp and reset done");
      complete_run();
   end

   initial begin
      #300_000;
      n_mismatch++;
      complete_run();
   end
endmodule // multichannel_dac_command_decoder_bench
